// ===== rtl/tpc_defines.vh
// constants shared by the temperature program command interpreter
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define TPC_CLK_NS 10
`define TPC_LOG_MS 1000
`define TPC_LOG_CYC (`TPC_LOG_MS * 1000000 / `TPC_CLK_NS)
// ----------------------------------------
// limits
// ----------------------------------------
`define TPC_MAX_LINE 7'd124
`define TPC_FAN_MAX 16'd100
`define TPC_NUM_SAT 16'd6552
// ----------------------------------------
// register byte offsets and fields
// ----------------------------------------
`define TPC_REG_CTRL 8'h00
`define TPC_REG_PERIOD 8'h04
`define TPC_REG_STATUS 8'h08
`define TPC_REG_SAMPLE 8'h0C
`define TPC_CTRL_LOG 0
// ----------------------------------------
// program entry layout
// ----------------------------------------
`define TPC_E_TIME 15:0
`define TPC_E_TEMP 31:16
`define TPC_E_RATE 47:32
`define TPC_E_EN 48
`define TPC_E_RST 49'h0
// ----------------------------------------
// characters
// ----------------------------------------
`define TPC_CR 8'h0D
`define TPC_LF 8'h0A
`define TPC_ESC 8'h1B
`define TPC_SP 8'h20
`define TPC_COMMA 8'h2C
`define TPC_RBRK 8'h5D
// ----------------------------------------
// reply kinds
// ----------------------------------------
`define TPC_K_OK 4'h0
`define TPC_K_ER 4'h1
`define TPC_K_CD 4'h2
`define TPC_K_OEQ 4'h3
`define TPC_K_OM 4'h4
`define TPC_K_ID 4'h5
`define TPC_K_ES 4'h6
`define TPC_K_LOG 4'h7
`define TPC_K_PR 4'h8
`define TPC_K_VR 4'h9
`define TPC_K_FM 4'hA
`endif

// ===== rtl/tpc_cmd_parser.v
// serial console command interpreter for a four-zone temperature programmer
// Operation
// [R1] two-char code plus operands; acted on only after carriage return
// [R2] bare code reads setting back; code with value sets it
// [R3] select_active_channel 1..4 sets active zone and names it in reply
// [R4] enable command: channel digit then flag digit, 1 enables, 0 disables
// [R5] bare enable command lists enabled or disabled for all four zones
// [R6] state-set prompts fields with current value; state 1 only temp and hold
// [R7] empty answer to a prompt keeps the bracketed value
// [R8] show_program prints eight rows: time, temp, rate, enable
// [R9] host checks program then issues save command
// [R10] log on starts periodic lines with index and per-zone data; log off stops
// [R11] initialize turns on enabled zones at state 1 temp; letter N then R
// [R12] de-initialize returns enabled zones to uncontrolled
// [R13] start runs program on zone 1..4 or on all with A; with A the code starts only zones both enabled and on
// [R14] cancel_program 1..4 stops that zone's program
// [R15] fan_wait_limit sets channel 1 fan percentage 0..100
// [R16] show_io_mapping lists sensing input of each zone
// [R17] command line limited to 124 characters
// [R18] codes decoded without regard to case
// [R19] every reply line ends with CR then LF
// [R20] link runs 115200 8N1 with flow control, framing outside
// [R21] unknown code or bad operand gives error and changes nothing
//
// Chosen here: the Wishbone register port and the register addresses.
`include "tpc_defines.vh"
`timescale 1ns/10ps
module tpc_cmd_parser #(
	parameter LOG_CYC = `TPC_LOG_CYC,
	// arbitrary version code
	parameter [15:0] VERSION = 16'h0100,
	// sensing input number of each zone, four bits per zone
	parameter [15:0] IO_MAP = 16'h4320
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// character stream
	input wire [7:0] rx_data_i,
	input wire rx_valid_i,
	output reg rx_ready_o,
	output reg [7:0] tx_data_o,
	output reg tx_valid_o,
	input wire tx_ready_i,
	// zone side
	input wire [3:0] zone_ready_i,
	input wire [63:0] meas_temp_i,
	input wire [63:0] power_i,
	output reg [3:0] zone_en_o,
	output reg [3:0] zone_on_o,
	output reg [3:0] zone_run_o,
	output reg [63:0] setpoint_o,
	output reg fan_on_o,
	output reg [6:0] fan_limit_o,
	output reg save_o
);
// ----------------------------------------
// states
// ----------------------------------------
localparam P_COL = 2'd0;
localparam P_EXEC = 2'd1;
localparam P_WAIT = 2'd2;
localparam E_IDLE = 3'd0;
localparam E_LOAD = 3'd1;
localparam E_PRE = 3'd2;
localparam E_VAL = 3'd3;
localparam E_BRK = 3'd4;
localparam E_CR = 3'd5;
localparam E_LF = 3'd6;
// ----------------------------------------
// functions
// ----------------------------------------
function [7:0] hexc;
	input [3:0] n;
	hexc = (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
endfunction
function [7:0] modec;
	input on, run, rdy;
	modec = !on ? "U" : run ? "A" : rdy ? "R" : "N";
endfunction
function [7:0] upc;
	input [7:0] b;
	upc = (b >= 8'h61 && b <= 8'h7A) ? b - 8'h20 : b;
endfunction
function inz;
	input [15:0] v;
	inz = (v >= 16'd1) && (v <= 16'd4);
endfunction
// ----------------------------------------
// storage
// ----------------------------------------
reg [48:0] mem [0:31];
reg [1:0] pstate;
reg [6:0] cnt;
reg [1:0] ncode;
reg [7:0] c0, c1;
reg [2:0] ndig;
reg [3:0] d0, d1;
reg [15:0] num;
reg alla, bad, ovf;
reg ss_mode;
reg [1:0] ss_fld;
reg [2:0] ss_state;
reg [1:0] act_zone;
reg log_on;
reg [31:0] log_period;
reg [3:0] req_kind, ekind;
reg [2:0] req_item, req_last, eitem, elast;
reg [1:0] req_zone, ezone;
reg req_go;
reg [2:0] estate, pos;
reg [1:0] vi;
reg [1:0] lpl;
reg [7:0] lc0, lc1, lc2;
reg [2:0] lnv;
reg lbrk;
reg [63:0] lvals;
reg [31:0] tmr;
reg log_pend;
reg [15:0] log_idx;
integer i;
wire [7:0] ub = upc(rx_data_i);
wire isdig = (rx_data_i >= 8'h30) && (rx_data_i <= 8'h39);
wire [3:0] dv = rx_data_i[3:0];
wire hasop = (ndig != 3'd0) || alla;
wire one = (ndig == 3'd1) && !alla;
wire [4:0] wix = {act_zone, ss_state};
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire slot = ~tx_valid_o | tx_ready_i;
// [R20] bytes arrive already deframed by the link
wire rx_take = rx_valid_i & rx_ready_o;
// write lands on the edge at which the master sees ack
wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
wire log_tick = log_on & (tmr >= log_period - 32'd1);
task clr_line;
	begin
		cnt <= 7'd0;
		ncode <= 2'd0;
		ndig <= 3'd0;
		num <= 16'h0000;
		alla <= 1'b0;
		bad <= 1'b0;
		ovf <= 1'b0;
	end
endtask
// ----------------------------------------
// parser, execution and register slave
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		pstate <= P_COL;
		clr_line;
		c0 <= 8'h00;
		c1 <= 8'h00;
		d0 <= 4'h0;
		d1 <= 4'h0;
		ss_mode <= 1'b0;
		ss_fld <= 2'd0;
		ss_state <= 3'd0;
		act_zone <= 2'd0;
		log_on <= 1'b0;
		log_period <= LOG_CYC;
		req_kind <= `TPC_K_OK;
		req_item <= 3'd0;
		req_last <= 3'd0;
		req_zone <= 2'd0;
		req_go <= 1'b0;
		rx_ready_o <= 1'b1;
		zone_en_o <= 4'h0;
		zone_on_o <= 4'h0;
		zone_run_o <= 4'h0;
		setpoint_o <= 64'h0;
		fan_on_o <= 1'b0;
		fan_limit_o <= 7'h00;
		save_o <= 1'b0;
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0;
		for (i = 0; i < 32; i = i + 1) mem[i] <= `TPC_E_RST;
	end else begin
		req_go <= 1'b0;
		save_o <= 1'b0;
		// [R11] zones that are on held at state 1 temperature
		setpoint_o <= {zone_on_o[3] ? mem[24][`TPC_E_TEMP] : 16'h0000,
			zone_on_o[2] ? mem[16][`TPC_E_TEMP] : 16'h0000,
			zone_on_o[1] ? mem[8][`TPC_E_TEMP] : 16'h0000,
			zone_on_o[0] ? mem[0][`TPC_E_TEMP] : 16'h0000};
		wb_ack_o <= wb_req;
		if (wb_wr && wb_adr_i == `TPC_REG_CTRL && wb_sel_i[0])
			log_on <= wb_dat_i[`TPC_CTRL_LOG];
		if (wb_wr && wb_adr_i == `TPC_REG_PERIOD) begin
			for (i = 0; i < 4; i = i + 1)
				if (wb_sel_i[i]) log_period[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
		end
		if (wb_req) begin
			case (wb_adr_i)
			`TPC_REG_CTRL: wb_dat_o <= {31'h0, log_on};
			`TPC_REG_PERIOD: wb_dat_o <= log_period;
			`TPC_REG_STATUS: wb_dat_o <= {10'h000, fan_limit_o, fan_on_o, zone_run_o,
				zone_on_o, zone_en_o, act_zone};
			`TPC_REG_SAMPLE: wb_dat_o <= {16'h0000, log_idx};
			default: wb_dat_o <= 32'h0;
			endcase
		end
		case (pstate)
		P_COL: if (rx_take) begin
			// [R1] carriage return ends the line
			if (rx_data_i == `TPC_CR) begin
				rx_ready_o <= 1'b0;
				pstate <= P_EXEC;
			end else if (rx_data_i == `TPC_ESC) begin
				clr_line;
			end else if (rx_data_i >= 8'h20 && rx_data_i <= 8'h7E) begin
				// [R17] overlong line flagged
				if (cnt == `TPC_MAX_LINE) ovf <= 1'b1;
				else cnt <= cnt + 7'd1;
				if (rx_data_i != `TPC_SP) begin
					// [R18] code stored upper case
					if (!ss_mode && ncode != 2'd2) begin
						if (ncode == 2'd0) c0 <= ub;
						else c1 <= ub;
						ncode <= ncode + 2'd1;
					end else if (isdig) begin
						if (ndig == 3'd0) d0 <= dv;
						if (ndig == 3'd1) d1 <= dv;
						if (ndig != 3'd7) ndig <= ndig + 3'd1;
						if (alla || num > `TPC_NUM_SAT) bad <= 1'b1;
						else num <= num * 16'd10 + {12'h000, dv};
					end else if (ub == "A" && ndig == 3'd0 && !ss_mode) begin
						alla <= 1'b1;
					end else begin
						bad <= 1'b1;
					end
				end
			end
		end
		P_EXEC: if (estate == E_IDLE) begin
			req_go <= 1'b1;
			pstate <= P_WAIT;
			req_kind <= `TPC_K_OK;
			req_item <= 3'd0;
			req_last <= 3'd0;
			req_zone <= act_zone;
			if (!ss_mode && ncode == 2'd0 && !hasop && !bad && !ovf) begin
				req_go <= 1'b0;
				pstate <= P_COL;
				rx_ready_o <= 1'b1;
				clr_line;
			end else if (ss_mode) begin
				// [R21] bad field aborts prompting, leaving that field unchanged
				if (bad || ovf || (ss_fld == 2'd3 && num > 16'd1)) begin
					ss_mode <= 1'b0;
					req_kind <= `TPC_K_ER;
				end else begin
					// [R7] empty answer keeps value
					if (ndig != 3'd0) begin
						case (ss_fld)
						2'd0: mem[wix][`TPC_E_TEMP] <= num;
						2'd1: mem[wix][`TPC_E_TIME] <= num;
						2'd2: mem[wix][`TPC_E_RATE] <= num;
						default: mem[wix][`TPC_E_EN] <= num[0];
						endcase
					end
					// [R6] state 1 stops after hold time
					if (ss_fld == ((ss_state == 3'd0) ? 2'd1 : 2'd3)) begin
						ss_mode <= 1'b0;
					end else begin
						ss_fld <= ss_fld + 2'd1;
						req_kind <= `TPC_K_PR;
						req_item <= {1'b0, ss_fld} + 3'd1;
						req_last <= {1'b0, ss_fld} + 3'd1;
					end
				end
			end else if (bad || ovf || ncode != 2'd2) begin
				req_kind <= `TPC_K_ER;
			end else begin
				// [R21] unknown codes answered with error
				req_kind <= `TPC_K_ER;
				case ({c0, c1})
				// [R3] active zone select and confirm
				"CD": if (one && inz(num)) begin
					act_zone <= num[1:0] - 2'd1;
					req_kind <= `TPC_K_CD;
				end else if (!hasop) req_kind <= `TPC_K_CD;
				// [R4] [R5] enable set or list
				"OE": if (!hasop) begin
					req_kind <= `TPC_K_OEQ;
					req_last <= 3'd3;
				end else if (ndig == 3'd2 && !alla && inz({12'h000, d0}) && d1 <= 4'd1) begin
					zone_en_o[d0[1:0] - 2'd1] <= d1[0];
					req_kind <= `TPC_K_OK;
				end
				// [R6] enter field prompting
				"SS": if (one && num >= 16'd1 && num <= 16'd8) begin
					ss_mode <= 1'b1;
					ss_state <= num[2:0] - 3'd1;
					ss_fld <= 2'd0;
					req_kind <= `TPC_K_PR;
				end
				// [R8] eight-row program table
				"ES": if (!hasop || (one && inz(num))) begin
					if (hasop) req_zone <= num[1:0] - 2'd1;
					req_kind <= `TPC_K_ES;
					req_last <= 3'd7;
				end
				// [R9] save strobe
				"WP": if (!hasop) begin
					save_o <= 1'b1;
					req_kind <= `TPC_K_OK;
				end
				// [R10] log on and off
				"L+": if (!hasop) begin
					log_on <= 1'b1;
					req_kind <= `TPC_K_OK;
				end
				"L-": if (!hasop) begin
					log_on <= 1'b0;
					req_kind <= `TPC_K_OK;
				end
				// [R11] initialize enabled zones
				"Z+": if (!hasop) begin
					zone_on_o <= zone_on_o | zone_en_o;
					req_kind <= `TPC_K_OK;
				end
				// [R12] release enabled zones
				"Z-": if (!hasop) begin
					zone_on_o <= zone_on_o & ~zone_en_o;
					zone_run_o <= zone_run_o & ~zone_en_o;
					req_kind <= `TPC_K_OK;
				end
				// [R13] start one zone, or all zones both enabled and on
				"GO": if (alla && ndig == 3'd0) begin
					zone_run_o <= zone_run_o | (zone_en_o & zone_on_o);
					req_kind <= `TPC_K_OK;
				end else if (one && inz(num)) begin
					zone_run_o[num[1:0] - 2'd1] <= 1'b1;
					req_kind <= `TPC_K_OK;
				end
				// [R14] cancel one zone
				"RS": if (one && inz(num)) begin
					zone_run_o[num[1:0] - 2'd1] <= 1'b0;
					req_kind <= `TPC_K_OK;
				end
				// [R15] [R2] fan limit read or set
				"FM": if (!hasop) req_kind <= `TPC_K_FM;
				else if (!alla && num <= `TPC_FAN_MAX) begin
					fan_limit_o <= num[6:0];
					req_kind <= `TPC_K_OK;
				end
				"F+": if (!hasop) begin
					fan_on_o <= 1'b1;
					req_kind <= `TPC_K_OK;
				end
				"F-": if (!hasop) begin
					fan_on_o <= 1'b0;
					req_kind <= `TPC_K_OK;
				end
				// [R16] mapping listing
				"OM": if (!hasop) begin
					req_kind <= `TPC_K_OM;
					req_last <= 3'd3;
				end
				"ID": if (!hasop) begin
					req_kind <= `TPC_K_ID;
					req_last <= 3'd3;
				end
				"VR": if (!hasop) req_kind <= `TPC_K_VR;
				default: req_kind <= `TPC_K_ER;
				endcase
			end
		end
		default: if (!req_go && estate == E_IDLE) begin
			pstate <= P_COL;
			rx_ready_o <= 1'b1;
			clr_line;
		end
		endcase
	end
end
// ----------------------------------------
// line content builder
// ----------------------------------------
reg [1:0] b_pl;
reg [7:0] b_c0, b_c1, b_c2;
reg [2:0] b_nv;
reg [63:0] b_v;
reg b_brk, b_skip;
reg [48:0] ent;
reg [7:0] mch;
always @* begin
	ent = mem[(ekind == `TPC_K_PR) ? {act_zone, ss_state} : {ezone, eitem}];
	mch = modec(zone_on_o[eitem[1:0]], zone_run_o[eitem[1:0]], zone_ready_i[eitem[1:0]]);
	b_pl = 2'd2;
	b_c0 = "Z";
	b_c1 = "1" + {5'h00, eitem};
	b_c2 = `TPC_SP;
	b_nv = 3'd0;
	b_v = 64'h0;
	b_brk = 1'b0;
	b_skip = 1'b0;
	case (ekind)
	`TPC_K_OK: begin b_pl = 2'd1; b_c0 = "O"; b_c1 = "K"; end
	`TPC_K_CD: begin b_pl = 2'd1; b_c0 = "A"; b_c1 = "1" + {6'h00, act_zone}; end
	`TPC_K_OEQ: b_c2 = zone_en_o[eitem[1:0]] ? "E" : "D";
	`TPC_K_OM: begin
		b_c2 = "M";
		b_nv = 3'd1;
		b_v = {12'h000, IO_MAP[{eitem[1:0], 2'b00} +: 4], 48'h0};
	end
	`TPC_K_ID: begin
		b_c2 = mch;
		b_nv = 3'd1;
		b_v = {meas_temp_i[{eitem[1:0], 4'h0} +: 16], 48'h0};
	end
	`TPC_K_LOG: begin
		// [R10] index and three values per enabled zone
		b_c0 = "C";
		b_c2 = mch;
		b_nv = 3'd4;
		b_v = {log_idx, setpoint_o[{eitem[1:0], 4'h0} +: 16],
			meas_temp_i[{eitem[1:0], 4'h0} +: 16], power_i[{eitem[1:0], 4'h0} +: 16]};
		b_skip = !zone_en_o[eitem[1:0]];
	end
	`TPC_K_ES: begin
		b_c0 = "S";
		b_c2 = ent[`TPC_E_EN] ? "1" : "0";
		b_nv = 3'd3;
		b_v = {ent[`TPC_E_TIME], ent[`TPC_E_TEMP], ent[`TPC_E_RATE], 16'h0};
	end
	`TPC_K_PR: begin
		b_c0 = "P";
		b_c1 = (eitem == 3'd0) ? "T" : (eitem == 3'd1) ? "H" : (eitem == 3'd2) ? "R" : "E";
		b_c2 = "[";
		b_nv = 3'd1;
		b_brk = 1'b1;
		b_v[63:48] = (eitem == 3'd0) ? ent[`TPC_E_TEMP] : (eitem == 3'd1) ? ent[`TPC_E_TIME] :
			(eitem == 3'd2) ? ent[`TPC_E_RATE] : {15'h0, ent[`TPC_E_EN]};
	end
	`TPC_K_VR: begin b_pl = 2'd1; b_c0 = "V"; b_c1 = "R"; b_nv = 3'd1; b_v[63:48] = VERSION; end
	`TPC_K_FM: begin b_pl = 2'd1; b_c0 = "F"; b_c1 = "M"; b_nv = 3'd1; b_v[54:48] = fan_limit_o; end
	default: begin b_pl = 2'd1; b_c0 = "E"; b_c1 = "R"; end
	endcase
end
reg [7:0] ch;
always @* begin
	case (estate)
	E_PRE: ch = (pos == 3'd0) ? lc0 : (pos == 3'd1) ? lc1 : lc2;
	E_VAL: ch = (pos != 3'd0) ? hexc(lvals[63:60]) : (vi == 2'd0) ? `TPC_SP : `TPC_COMMA;
	E_BRK: ch = `TPC_RBRK;
	E_CR: ch = `TPC_CR;
	default: ch = `TPC_LF;
	endcase
end
// ----------------------------------------
// reply emitter and log timer
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		estate <= E_IDLE;
		tx_valid_o <= 1'b0;
		tx_data_o <= 8'h00;
		{ekind, eitem, elast, ezone} <= 12'h000;
		{pos, vi, lpl, lnv, lbrk} <= 11'h000;
		{lc0, lc1, lc2} <= 24'h0;
		lvals <= 64'h0;
		tmr <= 32'h0;
		log_pend <= 1'b0;
		log_idx <= 16'hFFFF;
	end else begin
		if (tx_ready_i) tx_valid_o <= 1'b0;
		if (!log_on) begin
			tmr <= 32'h0;
			log_pend <= 1'b0;
			log_idx <= 16'hFFFF;
		end else if (tmr >= log_period - 32'd1) begin
			tmr <= 32'h0;
			log_pend <= 1'b1;
		end else begin
			tmr <= tmr + 32'd1;
		end
		case (estate)
		E_IDLE: if (req_go) begin
			{ekind, eitem, elast, ezone} <= {req_kind, req_item, req_last, req_zone};
			estate <= E_LOAD;
		end else if (log_pend && log_on && pstate == P_COL) begin
			ekind <= `TPC_K_LOG;
			eitem <= 3'd0;
			elast <= 3'd3;
			// a tick on this same edge stays pending
			log_pend <= log_tick;
			log_idx <= log_idx + 16'd1;
			estate <= E_LOAD;
		end
		E_LOAD: if (b_skip) begin
			if (eitem == elast) estate <= E_IDLE;
			else eitem <= eitem + 3'd1;
		end else begin
			{lpl, lc0, lc1, lc2, lnv, lbrk, lvals} <= {b_pl, b_c0, b_c1, b_c2, b_nv, b_brk, b_v};
			pos <= 3'd0;
			vi <= 2'd0;
			estate <= E_PRE;
		end
		default: if (slot) begin
			tx_data_o <= ch;
			tx_valid_o <= 1'b1;
			pos <= pos + 3'd1;
			case (estate)
			E_PRE: if (pos == {1'b0, lpl}) begin
				pos <= 3'd0;
				estate <= (lnv != 3'd0) ? E_VAL : lbrk ? E_BRK : E_CR;
			end
			E_VAL: begin
				if (pos != 3'd0) lvals <= {lvals[59:0], 4'h0};
				if (pos == 3'd4) begin
					pos <= 3'd0;
					vi <= vi + 2'd1;
					if ({1'b0, vi} + 3'd1 == lnv) estate <= lbrk ? E_BRK : E_CR;
				end
			end
			E_BRK: estate <= E_CR;
			// [R19] CR then LF closes each line
			E_CR: estate <= E_LF;
			default: if (eitem == elast) estate <= E_IDLE;
			else begin
				eitem <= eitem + 3'd1;
				estate <= E_LOAD;
			end
			endcase
		end
		endcase
	end
end
endmodule // tpc_cmd_parser

// ===== testbench/tpc_cmd_parser_assertions.sv
// port property checker for the temperature program command interpreter
`timescale 1ns/10ps
module tpc_cmd_parser_chk (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// register bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// character stream
	input wire [7:0] rx_data_i,
	input wire rx_valid_i,
	input wire rx_ready_o,
	input wire [7:0] tx_data_o,
	input wire tx_valid_o,
	input wire tx_ready_i,
	// zone side
	input wire [3:0] zone_on_o,
	input wire [63:0] setpoint_o,
	input wire [6:0] fan_limit_o,
	input wire save_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("bus ack longer than one cycle");
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("bus request not answered next cycle");
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("bus ack without request");
	property p_unmapped;
		wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_tx_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("reply char dropped before accepted");
	property p_cr_stop;
		rx_valid_i && rx_ready_o && rx_data_i == 8'h0D |=> !rx_ready_o;
	endproperty
	a_cr_stop: assert property (p_cr_stop)
		else $error("input still accepted after enter");
	property p_save;
		save_o |=> !save_o;
	endproperty
	a_save: assert property (p_save)
		else $error("save pulse longer than one cycle");
	property p_fan_max;
		fan_limit_o <= 7'h64;
	endproperty
	a_fan_max: assert property (p_fan_max)
		else $error("fan limit above full scale");
	property p_setpoint_off;
		({|setpoint_o[63:48], |setpoint_o[47:32], |setpoint_o[31:16], |setpoint_o[15:0]}
			& ~$past(zone_on_o)) == 4'h0;
	endproperty
	a_setpoint_off: assert property (p_setpoint_off)
		else $error("setpoint on a zone that is off");
endmodule // tpc_cmd_parser_chk

bind tpc_cmd_parser tpc_cmd_parser_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
	.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
	.zone_on_o(zone_on_o), .setpoint_o(setpoint_o), .fan_limit_o(fan_limit_o), .save_o(save_o));

// ===== testbench/tpc_host.sv
// host terminal model: types command lines, collects reply characters
`timescale 1ns/10ps
module tpc_host (
	// clock and mode
	input wire clk_i,
	input wire slow_i,
	// to the interpreter
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	input wire rx_ready_i,
	// from the interpreter
	input wire [7:0] tx_data_i,
	input wire tx_valid_i,
	output logic tx_ready_o
);
	byte q[$];
	logic [1:0] cnt = 2'h0;

	initial begin
		rx_data_o = 8'h00;
		rx_valid_o = 1'b0;
		tx_ready_o = 1'b1;
	end

	task send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_data_o <= s[i];
			rx_valid_o <= 1'b1;
			do @(posedge clk_i); while (rx_ready_i !== 1'b1);
		end
		rx_valid_o <= 1'b0;
		rx_data_o <= ~s[s.len() - 1];
	endtask

	task get_line(output string s);
		byte c;
		s = "";
		forever begin
			while (q.size() == 0) @(posedge clk_i);
			c = q.pop_front();
			if (c == 8'h0A) break;
			s = $sformatf("%s%c", s, c);
		end
	endtask

	// sink stalls three of four cycles in slow mode
	always @(posedge clk_i) begin
		cnt <= cnt + 2'h1;
		tx_ready_o <= slow_i ? (cnt == 2'h0) : 1'b1;
		if (tx_valid_i === 1'b1 && tx_ready_o)
			q.push_back(tx_data_i);
	end
endmodule // tpc_host

// ===== testbench/tb.sv
// self-checking bench for the temperature program command interpreter
`timescale 1ns/10ps
module tb;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
	logic [7:0] wb_adr_i, rx_data_i, tx_data_o;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i, zone_ready_i, zone_en_o, zone_on_o, zone_run_o;
	logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, fan_on_o, save_o;
	logic [63:0] setpoint_o;
	logic [6:0] fan_limit_o;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_save = 0;
	string s, ln;
	string oe[3] = '{"OE11", "OE21", "OE30"};

	tpc_cmd_parser #(.LOG_CYC(200)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_data_i(rx_data_i),
		.rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .zone_ready_i(zone_ready_i),
		.meas_temp_i(64'h0000000000330011), .power_i(64'h0000000000440022),
		.zone_en_o(zone_en_o), .zone_on_o(zone_on_o), .zone_run_o(zone_run_o),
		.setpoint_o(setpoint_o), .fan_on_o(fan_on_o), .fan_limit_o(fan_limit_o), .save_o(save_o));
	tpc_host host (.clk_i(clk_i), .slow_i(slow), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
		.rx_ready_i(rx_ready_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (save_o === 1'b1) n_save <= n_save + 1;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task reply(input string e);
		host.get_line(s);
		chk({"reply ", e}, s == {e, "\r"}, 1'b1);
	endtask
	task cmd(input string c, input string e);
		host.send({c, "\r"});
		reply(e);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		zone_ready_i = 4'h1;
		slow = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 8'h08, 32'h0); chk("status", rd, 32'h0);
		bus(0, 8'h0C, 32'h0); chk("sample", rd, 32'h0000FFFF);
		bus(1, 8'h10, 32'hFFFFFFFF);
		bus(0, 8'h10, 32'h0); chk("unmapped", rd, 32'h0);
		bus(0, 8'h04, 32'h0); chk("period", rd, 32'h000000C8);
		bus(1, 8'h04, 32'h0000012C);
		wb_sel_i <= 4'h1;
		bus(1, 8'h04, 32'hFFFFFF90);
		wb_sel_i <= 4'hF;
		bus(0, 8'h04, 32'h0); chk("period lanes", rd, 32'h00000190);
		host.send($sformatf("XY%cvr\r", 8'h1B));
		reply("VR 0100");
		cmd("cd2", "A2");
		bus(0, 8'h08, 32'h0); chk("active", rd[1:0], 2'h1);
		cmd("CD5", "ER");
		cmd("QQ", "ER");
		bus(0, 8'h08, 32'h0); chk("active kept", rd[1:0], 2'h1);
		foreach (oe[i]) cmd(oe[i], "OK");
		chk("enables", zone_en_o, 4'h3);
		slow <= 1'b1;
		cmd("OE", "Z1E");
		reply("Z2E"); reply("Z3D"); reply("Z4D");
		slow <= 1'b0;
		cmd("FM50", "OK");
		chk("fan", fan_limit_o, 7'h32);
		cmd("FM", "FM 0032");
		cmd("FM101", "ER");
		chk("fan kept", fan_limit_o, 7'h32);
		ln = "FM";
		repeat (122) ln = {ln, "0"};
		cmd(ln, "OK");
		chk("fan zero", fan_limit_o, 7'h00);
		cmd({ln, "0"}, "ER");
		host.send("SS1\r");
		host.get_line(s); chk("prompt T", s.substr(0, 1) == "PT", 1'b1);
		host.send("40\r");
		host.get_line(s); chk("prompt H", s.substr(0, 1) == "PH", 1'b1);
		host.send("\r");
		reply("OK");
		cmd("ss1", "PT[ 0028]");
		host.send("\r");
		reply("PH[ 0000]");
		host.send("\r");
		reply("OK");
		cmd("SS9", "ER");
		host.send("ES2\r");
		for (int i = 1; i <= 8; i++) begin
			host.get_line(s);
			chk("row", s.substr(0, 1) == $sformatf("S%0d", i), 1'b1);
			if (i == 1) chk("row one", s.substr(4, 17) == "0000,0028,0000", 1'b1);
		end
		cmd("Z+", "OK");
		chk("on", zone_on_o, 4'h3);
		@(posedge clk_i);
		chk("setpoint", setpoint_o, 64'h0000000000280000);
		cmd("L+", "OK");
		bus(0, 8'h00, 32'h0); chk("log on", rd[0], 1'b1);
		reply("C1R 0000,0000,0011,0022");
		reply("C2N 0000,0028,0033,0044");
		zone_ready_i <= 4'h3;
		reply("C1R 0001,0000,0011,0022");
		reply("C2R 0001,0028,0033,0044");
		host.send("L-\r");
		do host.get_line(s); while (s.substr(0, 0) == "C");
		chk("log off reply", s == "OK\r", 1'b1);
		host.q.delete();
		repeat (600) @(posedge clk_i);
		chk("quiet", host.q.size(), 0);
		bus(0, 8'h0C, 32'h0); chk("sample off", rd, 32'h0000FFFF);
		cmd("GOA", "OK");
		chk("run all", zone_run_o, 4'h3);
		cmd("ID", "Z1A 0011");
		reply("Z2A 0033"); reply("Z3U 0000"); reply("Z4U 0000");
		cmd("RS1", "OK");
		chk("run cut", zone_run_o, 4'h2);
		cmd("GO1", "OK");
		chk("run one", zone_run_o, 4'h3);
		cmd("Z-", "OK");
		chk("off", {zone_on_o, zone_run_o}, 8'h00);
		@(posedge clk_i);
		chk("setpoint off", setpoint_o, 64'h0);
		cmd("WP", "OK");
		chk("save", n_save, 1);
		cmd("OM", "Z1M 0000");
		reply("Z2M 0002"); reply("Z3M 0003"); reply("Z4M 0004");
		cmd("ID", "Z1U 0011");
		reply("Z2U 0033"); reply("Z3U 0000"); reply("Z4U 0000");
		cmd("F+", "OK");
		chk("fan on", fan_on_o, 1'b1);
		cmd("f-", "OK");
		chk("fan off", fan_on_o, 1'b0);
		conclude();
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end
endmodule // tb
